/* File: fap_core_model.sv */
/* core model: firmware side of the register port.
   assumes calls start just after a rising edge. */
`timescale 1ns/100ps
module fap_core_model (
  input wire logic mclk_in,
  input wire logic [7:0] sfr_rdata_in,
  output logic sfr_wr_out,
  output logic sfr_rd_out,
  output logic [7:0] sfr_addr_out,
  output logic [7:0] sfr_wdata_out
);
  logic [7:0] rd_q;
  // idle port from time zero
  initial {sfr_wr_out, sfr_rd_out, sfr_addr_out, sfr_wdata_out} = '0;
  // key codes reach the key in call order
  task automatic acc(input logic w, input logic [7:0] a, d);
    {sfr_wr_out, sfr_rd_out, sfr_addr_out, sfr_wdata_out} = {w, !w, a, d};
    @(posedge mclk_in) #1;
    rd_q = sfr_rdata_in;
    // released bus inverted so stale values never match
    {sfr_wr_out, sfr_rd_out, sfr_addr_out, sfr_wdata_out} = {2'b00, ~a, ~d};
    @(posedge mclk_in) #1;
  endtask
endmodule

/* File: fap_flash_protect.sv */
/*
  flash access protection: key lock, write/erase enables, lock byte
  page protection for firmware and debug port accesses.
  assumes single-cycle request strobes from core and debug logic on
  mclk_in, and that the flash macro acts only on the grant pulses.
  the lock byte shadow is loaded by the flash controller after boot;
  until then the reset value leaves every page unlocked.
  the error reset output must be fed back into the system reset,
  which also clears the key state held here.
*/
`timescale 1ns/100ps
module fap_flash_protect
  import fap_pkg::*;
(
  input wire logic mclk_in,
  input wire logic nrst_in,
  // special-function register port
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  // firmware flash requests
  input wire logic xwr_in,
  input wire logic cread_in,
  input wire logic xrd_in,
  input wire logic [FAP_ADDR_W-1:0] fw_addr_in,
  input wire logic [7:0] fw_wdata_in,
  input wire logic [FAP_ADDR_W-1:0] fetch_addr_in,
  output logic xwr_to_ram_out,
  output logic xrd_to_ram_out,
  output logic fw_grant_out,
  // debug port requests
  input wire logic dbg_rd_in,
  input wire logic dbg_wr_in,
  input wire logic dbg_erase_in,
  input wire logic dbg_chip_erase_in,
  input wire logic [FAP_ADDR_W-1:0] dbg_addr_in,
  input wire logic [7:0] dbg_wdata_in,
  output logic dbg_grant_out,
  output logic dbg_refused_out,
  // shadow of lock byte, loaded by flash controller at boot
  input wire logic lockb_load_in,
  input wire logic [7:0] lockb_value_in,
  output logic [7:0] lockb_out,
  // status
  output logic store_write_enable_out,
  output logic store_erase_enable_out,
  output logic read_oneshot_enable_out,
  output logic key_open_out,
  output logic key_dead_out,
  output logic flash_err_rst_out
);

  // whole state of the block, fields listed in the package
  fap_state_type st_reg;
  fap_state_type st_next;

  // lock state and code classification
  logic lock_pg_locked;
  logic fw_from_locked;
  logic store_write_enable;
  logic store_erase_enable;
  // firmware request decode
  logic fw_req;
  logic fw_erase;
  logic fw_ok;
  // debug request decode
  logic dbg_req;
  logic dbg_ok;
  // page numbers of target and issuing code
  logic [FAP_PAGE_W-1:0] fw_pg;
  logic [FAP_PAGE_W-1:0] dbg_pg;
  logic [FAP_PAGE_W-1:0] code_pg;
  logic fw_is_lockb;
  logic dbg_is_lockb;
  logic lockb_zero_to_one;
  // register port decode
  logic sfr_wr_ctrl;
  logic sfr_wr_scale;
  logic sfr_wr_key;

  // page locked test; count is the ones complement of the lock byte
  // nine bits so a count of 255 never wraps; pages 14 and 15 fall
  // inside a large count and are handled by their own checks
  function automatic logic pg_locked(input logic [FAP_PAGE_W-1:0] pg,
                                     input logic [7:0] lockb);
    logic [8:0] cnt;
    cnt = {1'b0, ~lockb};
    pg_locked = ({5'h00, pg} < cnt);
  endfunction

  // control register fields
  assign store_write_enable = st_reg.ctrl[FAP_WE_BIT];
  assign store_erase_enable = st_reg.ctrl[FAP_EE_BIT];
  // page numbers are the address bits above the page offset
  assign fw_pg = fw_addr_in[FAP_ADDR_W-1:FAP_PAGE_LSB];
  assign dbg_pg = dbg_addr_in[FAP_ADDR_W-1:FAP_PAGE_LSB];
  assign code_pg = fetch_addr_in[FAP_ADDR_W-1:FAP_PAGE_LSB];
  // register write strobes, one per mapped register
  assign sfr_wr_ctrl = sfr_wr_in && (sfr_addr_in == FAP_SFR_CTRL);
  assign sfr_wr_scale = sfr_wr_in && (sfr_addr_in == FAP_SFR_SCALE);
  assign sfr_wr_key = sfr_wr_in && (sfr_addr_in == FAP_SFR_KEY);
  assign fw_is_lockb = (fw_addr_in == FAP_LOCK_ADDR);
  assign dbg_is_lockb = (dbg_addr_in == FAP_LOCK_ADDR);
  assign lock_pg_locked = (st_reg.lockb != FAP_LOCKB_RST);
  assign fw_from_locked = pg_locked(code_pg, st_reg.lockb);
  // flash writes only with write enable; reads always to ram
  assign fw_req = (xwr_in && store_write_enable) || cread_in;
  assign fw_erase = xwr_in && store_erase_enable;
  assign xwr_to_ram_out = xwr_in && !store_write_enable;
  assign xrd_to_ram_out = xrd_in;
  // debug read, write or page erase; chip erase is separate
  assign dbg_req = dbg_rd_in || dbg_wr_in || dbg_erase_in;
  // a write may only clear lock bits
  // any data bit that would raise a cleared lock bit is an attack or a
  // bug; both are treated as a forbidden access
  assign lockb_zero_to_one = |(fw_wdata_in & ~st_reg.lockb);

  // firmware permission check
  // checks are ordered: reserved area first so that nothing can open
  // it, then the always readable lock byte, then the lock page, then
  // plain pages; the order is what makes the rules compose
  always_comb begin
    fw_ok = 1'b1;
    if (fw_pg == FAP_RSVD_PAGE) begin
      fw_ok = 1'b0;
    end else if (cread_in && fw_is_lockb) begin
      fw_ok = 1'b1;
    end else if (fw_pg == FAP_LOCK_PAGE) begin
      if (fw_erase) begin
        fw_ok = 1'b0;
      end else if (!fw_from_locked && lock_pg_locked) begin
        fw_ok = 1'b0;
      end else if (xwr_in && fw_is_lockb && lockb_zero_to_one) begin
        fw_ok = 1'b0;
      end
    end else if (pg_locked(fw_pg, st_reg.lockb) && !fw_from_locked) begin
      // locked pages only from locked code
      fw_ok = 1'b0;
    end else begin
      // unlocked pages open to all code
      fw_ok = 1'b1;
    end
  end

  // debug permission check
  // the debug port has no notion of code page, so it only sees
  // the lock state of the target page
  always_comb begin
    dbg_ok = 1'b1;
    if (dbg_pg == FAP_RSVD_PAGE) begin
      dbg_ok = 1'b0;
    end else if (dbg_rd_in && dbg_is_lockb) begin
      dbg_ok = 1'b1;
    end else if (dbg_pg == FAP_LOCK_PAGE) begin
      dbg_ok = !lock_pg_locked;
    end else begin
      dbg_ok = !pg_locked(dbg_pg, st_reg.lockb);
    end
  end

  // next-state logic
  // grants and the error request are one-cycle pulses, so they are
  // cleared first and only set by the paths below
  always_comb begin
    st_next = st_reg;
    st_next.fw_grant = 1'b0;
    st_next.dbg_grant = 1'b0;
    st_next.err_rst = 1'b0;
    // register writes
    if (sfr_wr_ctrl) begin
      st_next.ctrl = sfr_wdata_in[1:0];
    end
    if (sfr_wr_scale) begin
      st_next.scale_ose = sfr_wdata_in[FAP_OSE_BIT];
    end
    // key sequence; dead state holds until reset
    // timing between the two codes is free; only values and order count
    if (sfr_wr_key) begin
      case (st_reg.key)
        FAP_KEY_IDLE: begin
          // first code must open the sequence
          if (sfr_wdata_in == FAP_KEY1) begin
            st_next.key = FAP_KEY_HALF;
          end else begin
            st_next.key = FAP_KEY_DEAD;
          end
        end
        FAP_KEY_HALF: begin
          // second code completes it
          if (sfr_wdata_in == FAP_KEY2) begin
            st_next.key = FAP_KEY_OPEN;
          end else begin
            st_next.key = FAP_KEY_DEAD;
          end
        end
        FAP_KEY_OPEN: begin
          // a third code breaks the order
          st_next.key = FAP_KEY_DEAD;
        end
        FAP_KEY_DEAD: begin
          // only a system reset leaves this state
          st_next.key = FAP_KEY_DEAD;
        end
        default: begin
          st_next.key = FAP_KEY_DEAD;
        end
      endcase
    end
    // firmware flash access
    // a refused access never reaches the flash; the error reset that
    // follows restarts the core, so an open lock is closed as well
    if (fw_req) begin
      if (!fw_ok) begin
        st_next.err_rst = 1'b1;
        if (st_reg.key == FAP_KEY_OPEN) begin
          st_next.key = FAP_KEY_IDLE;
        end
      end else if (cread_in) begin
        st_next.fw_grant = 1'b1;
      end else if (st_reg.key != FAP_KEY_OPEN) begin
        // write without key kills the lock
        st_next.key = FAP_KEY_DEAD;
      end else begin
        // enables already part of fw_req and fw_erase
        st_next.fw_grant = 1'b1;
        st_next.key = FAP_KEY_IDLE;
        // shadow follows a granted lock byte write
        if (!fw_erase && fw_is_lockb) begin
          st_next.lockb = st_reg.lockb & fw_wdata_in;
        end
      end
    end
    // debug accesses; writes can only clear lock bits
    // chip erase wins over any other debug request in the same cycle
    if (dbg_chip_erase_in) begin
      st_next.lockb = FAP_LOCKB_RST;
      st_next.dbg_grant = 1'b1;
    end else if (dbg_req && dbg_ok) begin
      st_next.dbg_grant = 1'b1;
      // a debug write can only clear bits, as the flash would
      if (dbg_wr_in && dbg_is_lockb) begin
        st_next.lockb = st_reg.lockb & dbg_wdata_in;
      end else if (dbg_erase_in && dbg_pg == FAP_LOCK_PAGE) begin
        // erasing the lock page restores the lock byte
        st_next.lockb = FAP_LOCKB_RST;
      end
    end
    // boot load of the shadow wins; it mirrors what the flash holds
    if (lockb_load_in) begin
      st_next.lockb = lockb_value_in;
    end
    // register read data
    // the key register reads as zero so the codes cannot be snooped
    st_next.sfr_rdata = 8'h00;
    if (sfr_rd_in) begin
      case (sfr_addr_in)
        FAP_SFR_CTRL: begin
          // enables in the low two bits
          st_next.sfr_rdata = {6'h00, st_reg.ctrl};
        end
        FAP_SFR_SCALE: begin
          // reserved bits read as zero
          st_next.sfr_rdata = {st_reg.scale_ose, 7'h00};
        end
        default: begin
          // unmapped and key reads give zero
          st_next.sfr_rdata = 8'h00;
        end
      endcase
    end
  end

  // state register
  // one register for all state keeps reset values in one place
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_reg <= '{
        key: FAP_KEY_IDLE,
        ctrl: FAP_CTRL_RST,
        scale_ose: FAP_SCALE_RST[FAP_OSE_BIT],
        lockb: FAP_LOCKB_RST,
        sfr_rdata: 8'h00,
        fw_grant: 1'b0,
        dbg_grant: 1'b0,
        err_rst: 1'b0
      };
    end else begin
      // registered copy of the next state
      st_reg <= st_next;
    end
  end

  // outputs from registers, except the refusal flag
  // the refusal flag is combinational so the debug logic can abort
  // the transfer in the cycle it is asked for; a chip erase is never
  // refused, since it wipes whatever it would expose
  assign sfr_rdata_out = st_reg.sfr_rdata;
  assign fw_grant_out = st_reg.fw_grant;
  assign dbg_grant_out = st_reg.dbg_grant;
  assign dbg_refused_out = dbg_req && !dbg_ok && !dbg_chip_erase_in;
  assign lockb_out = st_reg.lockb;
  assign store_write_enable_out = store_write_enable;
  assign store_erase_enable_out = store_erase_enable;
  assign read_oneshot_enable_out = st_reg.scale_ose;
  assign key_open_out = (st_reg.key == FAP_KEY_OPEN);
  assign key_dead_out = (st_reg.key == FAP_KEY_DEAD);
  assign flash_err_rst_out = st_reg.err_rst;
endmodule

/* File: fap_pkg.sv */
/*
  constants and types for the flash access protection block.
  assumes an 8 kB flash in 512-byte pages with a special-function
  register port driven by the core on the same clock.
*/
package fap_pkg;
  localparam int unsigned FAP_ADDR_W = 13;
  localparam int unsigned FAP_PAGE_W = 4;
  localparam int unsigned FAP_PAGE_LSB = 9;   // 512-byte pages
  // top reserved page, 0x1e00..0x1fff
  localparam logic [FAP_PAGE_W-1:0] FAP_RSVD_PAGE = 4'hf;
  // lock byte is the last byte of user space
  localparam logic [FAP_ADDR_W-1:0] FAP_LOCK_ADDR = 13'h1dff;
  localparam logic [FAP_PAGE_W-1:0] FAP_LOCK_PAGE = 4'he;
  // special-function register addresses
  localparam logic [7:0] FAP_SFR_CTRL = 8'h8f;
  localparam logic [7:0] FAP_SFR_KEY = 8'hb7;
  localparam logic [7:0] FAP_SFR_SCALE = 8'hb6;
  // field positions
  localparam int unsigned FAP_WE_BIT = 0;
  localparam int unsigned FAP_EE_BIT = 1;
  localparam int unsigned FAP_OSE_BIT = 7;
  // reset values
  localparam logic [7:0] FAP_SCALE_RST = 8'h80;
  localparam logic [1:0] FAP_CTRL_RST = 2'h0;
  localparam logic [7:0] FAP_LOCKB_RST = 8'hff;
  // unlock codes
  localparam logic [7:0] FAP_KEY1 = 8'ha5;
  localparam logic [7:0] FAP_KEY2 = 8'hf1;

  typedef enum logic [1:0] {
    FAP_KEY_IDLE = 2'b00,
    FAP_KEY_HALF = 2'b01,
    FAP_KEY_OPEN = 2'b10,
    FAP_KEY_DEAD = 2'b11
  } fap_key_type;

  typedef struct packed {
    fap_key_type key;
    logic [1:0] ctrl;
    logic scale_ose;
    logic [7:0] lockb;
    logic [7:0] sfr_rdata;
    logic fw_grant;
    logic dbg_grant;
    logic err_rst;
  } fap_state_type;
endpackage

/* File: fap_protect_properties.sv */
/* port checker for fap_flash_protect.
   assumes binding by port name, one clock. */
`timescale 1ns/100ps
module fap_protect_properties import fap_pkg::*; (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic cread_in,
  input wire logic xwr_in,
  input wire logic [12:0] fw_addr_in,
  input wire logic dbg_rd_in,
  input wire logic dbg_chip_erase_in,
  input wire logic [12:0] dbg_addr_in,
  input wire logic fw_grant_out,
  input wire logic dbg_grant_out,
  input wire logic dbg_refused_out,
  input wire logic [7:0] lockb_out,
  input wire logic store_write_enable_out,
  input wire logic key_open_out,
  input wire logic key_dead_out,
  input wire logic flash_err_rst_out
);
  // checks sleep while reset is low
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  lock_read_free_a: assert property (
    dbg_rd_in && dbg_addr_in == FAP_LOCK_ADDR |=> dbg_grant_out)
    else $error("lock read");
  dbg_rsvd_a: assert property (
    dbg_rd_in && dbg_addr_in[12:9] == FAP_RSVD_PAGE |-> dbg_refused_out)
    else $error("rsvd");
  refused_no_grant_a: assert property (
    dbg_refused_out |=> !dbg_grant_out) else $error("refused granted");
  chip_erase_wipe_a: assert property (
    dbg_chip_erase_in |=> dbg_grant_out && lockb_out == 8'hff)
    else $error("chip erase");
  fw_rsvd_err_a: assert property (
    cread_in && fw_addr_in[12:9] == FAP_RSVD_PAGE
    |=> flash_err_rst_out && !fw_grant_out) else $error("rsvd firmware read");
  write_needs_key_a: assert property (
    xwr_in && store_write_enable_out && !key_open_out |=> !fw_grant_out)
    else $error("key");
  key_relock_a: assert property (
    xwr_in && store_write_enable_out && key_open_out |=> !key_open_out)
    else $error("relock");
  dead_sticky_a: assert property (
    key_dead_out |=> key_dead_out) else $error("dead key revived");
  fw_grant_c: cover property (fw_grant_out);
  err_rst_c: cover property (flash_err_rst_out);
  refused_c: cover property (dbg_refused_out);
endmodule
bind fap_flash_protect fap_protect_properties i_props (.mclk_in, .nrst_in,
  .cread_in, .xwr_in, .fw_addr_in, .dbg_rd_in, .dbg_chip_erase_in,
  .dbg_addr_in, .fw_grant_out, .dbg_grant_out, .dbg_refused_out, .lockb_out,
  .store_write_enable_out, .key_open_out, .key_dead_out, .flash_err_rst_out);

/* File: tb_fap_flash_protect.sv */
/* bench: random and directed flash accesses against a scoreboard.
   assumes fap_core_model drives the register port. */
`timescale 1ns/100ps
module tb_fap_flash_protect import fap_pkg::*; ;
  logic mclk_in = 1'b0;
  logic nrst_in, cread_in, xwr_in, xrd_in, lockb_load_in, sfr_wr, sfr_rd, g;
  logic dbg_rd_in, dbg_chip_erase_in, fw_grant_out, dbg_grant_out;
  logic dbg_refused_out, key_open_out, key_dead_out, flash_err_rst_out;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_out, lockb_value_in, lockb_out;
  logic [12:0] fw_addr_in, fetch_addr_in, dbg_addr_in;
  int n_errors = 0, n_compared = 0, seed = 85, lb = 255, a, fa;
  fap_core_model i_fap_core_model (.mclk_in, .sfr_rdata_in(sfr_rdata_out),
    .sfr_wr_out(sfr_wr), .sfr_rd_out(sfr_rd), .sfr_addr_out(sfr_addr),
    .sfr_wdata_out(sfr_wdata));
  fap_flash_protect i_fap_flash_protect (.mclk_in, .nrst_in, .xwr_in,
    .sfr_wr_in(sfr_wr), .sfr_rd_in(sfr_rd), .sfr_addr_in(sfr_addr),
    .sfr_wdata_in(sfr_wdata), .sfr_rdata_out, .cread_in, .xrd_in,
    .fw_addr_in, .fw_wdata_in(8'h00), .fetch_addr_in, .xwr_to_ram_out(),
    .xrd_to_ram_out(), .fw_grant_out, .dbg_rd_in, .dbg_wr_in(1'b0),
    .dbg_erase_in(1'b0), .dbg_chip_erase_in, .dbg_addr_in,
    .dbg_wdata_in(8'h00), .dbg_grant_out, .dbg_refused_out, .lockb_load_in,
    .lockb_value_in, .lockb_out, .store_write_enable_out(),
    .store_erase_enable_out(), .read_oneshot_enable_out(), .key_open_out,
    .key_dead_out, .flash_err_rst_out);
  // 200 MHz clock
  initial forever #2.5 mclk_in = ~mclk_in;
  // hang guard, about ten times the expected run
  initial begin
    #20000;
    n_errors++;
    finish_test();
  end
  task automatic chk(input logic [7:0] v, e);
    n_compared++;
    if (v !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, v, e);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // page locked by the ones complement count
  function automatic bit lk(int pg);
    return pg < (~lb & 255) || (pg == 14 && lb != 255);
  endfunction
  function automatic bit ok(bit d, int fa, int a);
    if (a == 'h1dff || a >> 9 == 15) return a == 'h1dff;
    return (d || !lk(fa >> 9)) ? !lk(a >> 9) : 1'b1;
  endfunction
  // one request, checked same cycle and one cycle later
  task automatic req(input bit d, input int op, fa, a, input bit g, e);
    {fetch_addr_in, fw_addr_in, dbg_addr_in} = {fa[12:0], a[12:0], a[12:0]};
    {cread_in, xwr_in, xrd_in} = d ? 3'h0 : 3'h4 >> op;
    {dbg_rd_in, dbg_chip_erase_in} = d ? 2'h2 >> op : 2'h0;
    #1 chk(dbg_refused_out, d && !g);
    @(posedge mclk_in) #1;
    chk(d ? dbg_grant_out : fw_grant_out, g);
    chk(flash_err_rst_out, e);
    {cread_in, xwr_in, xrd_in, dbg_rd_in, dbg_chip_erase_in} = '0;
    @(posedge mclk_in) #1;
  endtask
  // main sequence
  initial begin
    {nrst_in, cread_in, xwr_in, xrd_in, lockb_load_in} = '0;
    {dbg_rd_in, dbg_chip_erase_in, lockb_value_in} = '0;
    {fw_addr_in, fetch_addr_in, dbg_addr_in} = '0;
    repeat (16) @(posedge mclk_in);
    #1 nrst_in = 1'b1;
    i_fap_core_model.acc(1'b0, FAP_SFR_SCALE, 8'h00);
    chk(i_fap_core_model.rd_q, FAP_SCALE_RST);
    i_fap_core_model.acc(1'b1, FAP_SFR_CTRL, 8'h03);
    for (int i = 0; i < 5; i++) begin
      lb = (i == 4) ? 'hfd : $random(seed) & 255;
      lockb_value_in = lb[7:0];
      lockb_load_in = 1'b1;
      @(posedge mclk_in) #1;
      lockb_load_in = 1'b0;
      chk(lockb_out, lb[7:0]);
      repeat (20) begin
        a = $random(seed) & 'h1fff;
        fa = {$random(seed)} % 'h1c00;
        g = ok(0, fa, a);
        req(1, 0, fa, a, ok(1, fa, a), 0);
        req(0, a & 2, fa, a, g && !(a & 2), !g && !(a & 2));
      end
    end
    req(1, 0, 0, 'h1dff, 1, 0);
    req(0, 0, 'h600, 'h1c00, 0, 1);
    req(0, 0, 0, 'h1c00, 1, 0);
    i_fap_core_model.acc(1'b1, FAP_SFR_KEY, FAP_KEY1);
    i_fap_core_model.acc(1'b1, FAP_SFR_KEY, FAP_KEY2);
    req(0, 1, 0, 'h1c00, 0, 1);
    i_fap_core_model.acc(1'b1, FAP_SFR_KEY, FAP_KEY1);
    i_fap_core_model.acc(1'b1, FAP_SFR_KEY, FAP_KEY2);
    req(0, 1, 'h600, 'h400, 1, 0);
    req(0, 1, 'h600, 'h400, 0, 0);
    chk(key_dead_out, 1'b1);
    req(1, 1, 0, 0, 1, 0);
    chk(lockb_out, 8'hff);
    finish_test();
  end
endmodule
